// ---- testbench/pcnr_far_model.sv ----
// Far side pin model: external sources and the device pin drivers meet on one wire per pin.
// Assumes the bench drives the external level synchronously to pclk.
`timescale 1ns/1ps

module pcnr_far_model (
  // Device pin drive
  input  wire [15:0] pin_out,
  input  wire [15:0] pin_oe,
  // External source level
  input  wire [15:0] ext_lvl,
  // Level seen by the device
  output wire [15:0] pin_in
);
  // Driven pins read back the device, no pull fights an output pin
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_lvl);
endmodule

// ---- testbench/pcnr_top_asserts.sv ----
// Port checker for the notify and remap block: APB answer timing and register field shapes.
// Assumes one pclk domain, presetn active low; bound to every pcnr_top instance below.
`timescale 1ns/1ps

module pcnr_top_asserts (
  // Clock and reset
  input wire        pclk,
  input wire        presetn,
  // APB slave side
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [11:0] paddr,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  // Pin and peripheral side
  input wire [15:0] pin_oe,
  input wire [7:0]  periph_in
);
  // Completed transfer at this edge
  wire acc;
  assign acc = psel && penable && pready;

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_READY_ONE: assert property (pready |=> !pready)
    else $error("pready held longer than one cycle");
  AST_READY_SLOT: assert property (psel && penable && !pready |=> pready)
    else $error("pready late after first access edge");
  AST_READY_REQ: assert property (pready |-> psel && penable)
    else $error("pready without an access phase");
  AST_LOCKED_OK: assert property (acc && pwrite && (paddr[11:4] == 8'h04 || paddr[11:5] == 7'h03)
                                  && paddr[1:0] == 2'b00 |-> !pslverr)
    else $error("map write answered with error");
  AST_RESET_QUIET: assert property ($rose(presetn) |-> (pin_oe == 16'h0000 && periph_in == 8'h00)[*3])
    else $error("pins or peripheral inputs active after reset");
  AST_KEY_ZERO: assert property (acc && !pwrite && paddr == 12'h028 |-> prdata == 32'h00000000)
    else $error("key register read not zero");
  AST_LOCK_BIT: assert property (acc && !pwrite && paddr == 12'h024 |-> (prdata & 32'hfffff7ff) == 32'h0)
    else $error("map control has bits beside the lock");
  AST_OSEL_WIDTH: assert property (acc && !pwrite && paddr[11:5] == 7'h03 |-> (prdata & 32'hffffc0c0) == 32'h0)
    else $error("output selector wider than six bits");
  AST_ISEL_WIDTH: assert property (acc && !pwrite && paddr[11:4] == 8'h04 |-> prdata[31:16] == 16'h0000)
    else $error("input map upper half not zero");
endmodule

bind pcnr_top pcnr_top_asserts u_pcnr_top_asserts (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .pin_oe(pin_oe), .periph_in(periph_in));

// ---- testbench/tb_top.sv ----
// Self-checking bench for pcnr_top: APB master tasks and one task per scenario.
// Assumes pcnr_top, the far model and the bound checker are compiled before it.
`timescale 1ns/1ps

module tb_top;
  // Clock, reset, APB
  reg         pclk    = 1'b0;
  reg         presetn = 1'b0;
  reg         psel    = 1'b0;
  reg         penable = 1'b0;
  reg         pwrite  = 1'b0;
  reg  [11:0] paddr   = 12'h000;
  reg  [31:0] pwdata  = 32'h0;
  wire [31:0] prdata;
  wire        pready;
  wire        pslverr;
  // Pins and peripherals
  reg  [15:0] drv     = 16'h0000;
  wire [15:0] pin_in;
  wire [15:0] pin_out;
  wire [15:0] pin_oe;
  reg  [12:1] isig    = 12'h000;
  wire [7:0]  periph_in;
  reg  [7:0]  pout    = 8'h00;
  reg  [7:0]  poe     = 8'h00;
  reg  [15:0] fen     = 16'h0000;
  reg  [15:0] fout    = 16'h0000;
  reg  [15:0] foe     = 16'h0000;
  wire        notify_irq;
  // Results
  integer     errors      = 0;
  integer     checks_done = 0;
  reg  [31:0] q;
  reg         e;

  always #50 pclk = ~pclk;

  pcnr_top u_pcnr_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .internal_sig(isig), .periph_in(periph_in), .periph_out(pout), .periph_oe(poe),
    .fixed_en(fen), .fixed_out(fout), .fixed_oe(foe), .notify_irq(notify_irq));

  pcnr_far_model u_pcnr_far_model (.pin_out(pin_out), .pin_oe(pin_oe), .ext_lvl(drv), .pin_in(pin_in));

  // Verdict and end of run
  task report_and_stop;
    begin
      if (errors == 0 && checks_done > 0)
        $display("NO MISMATCHES");
      else
        $display("MISMATCHES SEEN");
      $finish;
    end
  endtask

  // Compare and count
  task chk(input [31:0] g, input [31:0] x);
    begin
      checks_done = checks_done + 1;
      if (g !== x) begin
        errors = errors + 1;
        $display("ERROR t=%0t got=%h exp=%h", $time, g, x);
      end
    end
  endtask

  // One APB transfer, held until pready is sampled high
  task apb(input [11:0] a, input w, input [31:0] d);
    integer n;
    begin
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      @(posedge pclk);
      while (pready !== 1'b1 && n < 20) begin
        @(posedge pclk);
        n = n + 1;
      end
      // A handshake that never answers counts as a mismatch
      if (pready !== 1'b1) begin
        errors = errors + 1;
        $display("ERROR t=%0t got=%h exp=%h", $time, pready, 1'b1);
      end
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask

  task wr(input [11:0] a, input [31:0] d);
    apb(a, 1'b1, d);
  endtask

  // Read and compare
  task rc(input [11:0] a, input [31:0] x);
    begin
      apb(a, 1'b0, 32'h0);
      chk(q, x);
    end
  endtask

  task s3;
    repeat (3) @(posedge pclk);
  endtask

  // Drive the external pin levels and let them settle
  task pin(input [15:0] v);
    begin
      @(posedge pclk);
      drv <= v;
      repeat (4) @(posedge pclk);
    end
  endtask

  // Reset values of map registers and the map control register
  task t_reset;
    reg [11:0] a;
    begin
      for (a = 12'h040; a < 12'h050; a = a + 12'h004)
        rc(a, 32'hffff);
      for (a = 12'h060; a < 12'h080; a = a + 12'h004)
        rc(a, 32'h0);
      rc(12'h024, 32'h0);
      apb(12'h030, 1'b0, 32'h0);
      chk({31'h0, e}, 32'h1);
    end
  endtask

  // Lock, keyed changes, abandoned key sequence
  task t_lock;
    begin
      wr(12'h040, 32'h2120);
      rc(12'h040, 32'h2120);
      wr(12'h024, 32'h800);
      rc(12'h024, 32'h0);
      wr(12'h028, 32'h55);
      wr(12'h028, 32'haa);
      wr(12'h024, 32'h800);
      rc(12'h024, 32'h800);
      wr(12'h040, 32'h0);
      chk({31'h0, e}, 32'h0);
      rc(12'h040, 32'h2120);
      wr(12'h060, 32'h1);
      rc(12'h060, 32'h0);
      wr(12'h028, 32'h55);
      wr(12'h004, 32'h0);
      wr(12'h028, 32'haa);
      wr(12'h024, 32'h0);
      rc(12'h024, 32'h800);
      wr(12'h028, 32'h55);
      wr(12'h028, 32'haa);
      wr(12'h024, 32'h0);
      wr(12'h040, 32'h1);
      wr(12'h044, 32'h1);
      rc(12'h040, 32'h1);
      rc(12'h044, 32'h1);
    end
  endtask

  // Input selector indices: ground, internal sources, pins, reserved
  task t_insel;
    reg [7:0] k;
    begin
      wr(12'h020, 32'h0);
      for (k = 8'd1; k < 8'd13; k = k + 8'd1) begin
        wr(12'h040, {16'h0, 8'hff, k});
        isig <= 12'h001 << (k - 8'd1);
        s3;
        chk(periph_in[0], 1);
        isig <= ~(12'h001 << (k - 8'd1));
        s3;
        chk(periph_in[0], 0);
      end
      for (k = 8'd0; k < 8'd16; k = k + 8'd1) begin
        wr(12'h040, {16'h0, 8'hff, 8'd32 + k});
        pin(16'h0001 << k);
        chk(periph_in[0], 1);
        pin(~(16'h0001 << k));
        chk(periph_in[0], 0);
      end
      isig <= 12'hfff;
      pin(16'hffff);
      wr(12'h040, 32'h0d00);
      s3;
      chk(periph_in[1:0], 2'b00);
      wr(12'h040, 32'h0100);
      s3;
      chk(periph_in[1:0], 2'b10);
      wr(12'h040, 32'hffff);
    end
  endtask

  // Output selector, override of fixed function, analog priority
  task t_outsel;
    begin
      wr(12'h018, 32'hfffe);
      wr(12'h01c, 32'h1);
      fen <= 16'h0001;
      foe <= 16'h0001;
      pout <= 8'h81;
      poe <= 8'h81;
      s3;
      chk(pin_out[0], 0);
      wr(12'h060, 32'h1);
      s3;
      chk({pin_oe[0], pin_out[0]}, 2'b11);
      wr(12'h060, 32'h8);
      pout <= 8'h80;
      s3;
      chk(pin_out[0], 1);
      wr(12'h060, 32'h9);
      s3;
      chk(pin_out[0], 0);
      wr(12'h060, 32'h8);
      wr(12'h020, 32'h1);
      s3;
      chk(pin_oe[0], 0);
      wr(12'h060, 32'h0);
      wr(12'h020, 32'h0);
      wr(12'h018, 32'hffff);
      wr(12'h01c, 32'h0);
      fen <= 16'h0000;
    end
  endtask

  // Mismatch style, direction gating, notify on bit
  task t_mismatch;
    begin
      pin(16'h0000);
      wr(12'h000, 32'h8000);
      wr(12'h004, 32'h1);
      wr(12'h008, 32'h2);
      apb(12'h014, 1'b0, 32'h0);
      pin(16'h0003);
      rc(12'h00c, 32'h1);
      chk(notify_irq, 1);
      rc(12'h014, 32'h3);
      rc(12'h00c, 32'h0);
      chk(notify_irq, 0);
      wr(12'h018, 32'hfffe);
      pin(16'h0002);
      chk(notify_irq, 0);
      wr(12'h018, 32'hffff);
      s3;
      chk(notify_irq, 1);
      wr(12'h000, 32'h0);
      apb(12'h014, 1'b0, 32'h0);
      pin(16'h0003);
      rc(12'h00c, 32'h0);
      chk(notify_irq, 0);
    end
  endtask

  // Edge style: every enable pair, flag holding and clearing
  task t_edge;
    reg [1:0] m;
    integer   i;
    begin
      pin(16'h0000);
      wr(12'h000, 32'h8800);
      for (i = 0; i < 4; i = i + 1) begin
        m = i[1:0];
        wr(12'h004, {31'h0, m[0]});
        wr(12'h008, {31'h0, m[1]});
        wr(12'h010, 32'h0);
        pin(16'h0001);
        rc(12'h010, {31'h0, m[0]});
        wr(12'h010, 32'h0);
        pin(16'h0000);
        rc(12'h010, {31'h0, m[1]});
      end
      chk(notify_irq, 1);
      pin(16'h0001);
      wr(12'h010, 32'h1);
      rc(12'h010, 32'h1);
      wr(12'h010, 32'h0);
      s3;
      chk(notify_irq, 0);
      pin(16'h0000);
      chk(notify_irq, 1);
      wr(12'h000, 32'h0);
    end
  endtask

  // Main sequence
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    t_lock;
    t_insel;
    t_outsel;
    t_mismatch;
    t_edge;
    report_and_stop;
  end

  // Watchdog against a hung handshake
  initial begin
    #2000000;
    errors = errors + 1;
    report_and_stop;
  end
endmodule

// ---- verilog/pcnr_defines.vh ----
// Constants for the port change notify and pin remap block: offsets, fields, resets, keys.
// Assumes inclusion by bare name from files under verilog/; definitions only.
//
// Overview of operation
// - Mismatch style: first enable detects pin changes
// - Edge style: enable pair picks rise/fall/both
// - Status bit marks change since value read
// - Edge flag sticks until software clears it
// - Notify interrupt only for input-direction pins
// - Locked map writes complete, contents unchanged
// - Lock bit 11 of map control blocks
// - Lock changes only after 0x55, 0xAA keys
// - Lock holds value until explicitly changed
// - Reset: input maps ones, output maps zeros
// - Lock resets to unlocked
// - Eight-bit input selector picks source index
// - Input indices: ground, comparators, clock, triggers, PWM
// - Remapped peripheral overrides other digital pin functions
// - Remapping never overrides analog pin function
// - Remappables unconnected until mapped; fixed stay fixed
// - Notification works only while port on bit set
// - Six-bit output selector, zero means null
`ifndef PCNR_DEFINES_VH
`define PCNR_DEFINES_VH

// Sizes
`define PCNR_NPIN          16
`define PCNR_NPERIN        8
`define PCNR_NPEROUT       8
`define PCNR_NIMAP         4
`define PCNR_NOMAP         8

// Register byte offsets
`define PCNR_OFS_NCTL      12'h000
`define PCNR_OFS_EN_FIRST  12'h004
`define PCNR_OFS_EN_SECOND 12'h008
`define PCNR_OFS_MSTAT     12'h00c
`define PCNR_OFS_EFLAG     12'h010
`define PCNR_OFS_PINVAL    12'h014
`define PCNR_OFS_DIR       12'h018
`define PCNR_OFS_LATCH     12'h01c
`define PCNR_OFS_ANALOG    12'h020
`define PCNR_OFS_MAPCTL    12'h024
`define PCNR_OFS_KEY       12'h028
`define PCNR_OFS_IMAP      12'h040
`define PCNR_OFS_OMAP      12'h060

// Field positions
`define PCNR_NCTL_ON       15
`define PCNR_NCTL_STYLE    11
`define PCNR_MAPCTL_LOCK   11

// Reset values
`define PCNR_DIR_RST       16'hffff
`define PCNR_ANALOG_RST    16'hffff
`define PCNR_IMAP_RST      16'hffff
`define PCNR_OMAP_RST      16'h0000
`define PCNR_LOCK_RST      1'b0

// Unlock keys
`define PCNR_KEY_FIRST     8'h55
`define PCNR_KEY_SECOND    8'haa

// Input selector index map
`define PCNR_ISEL_INT_LAST 8'd12
`define PCNR_ISEL_RP_BASE  8'd32
`define PCNR_ISEL_RP_LAST  8'd47

// Output selector codes
`define PCNR_OSEL_NULL     6'd0
`define PCNR_OSEL_LAST     6'd8

`endif

// ---- verilog/pcnr_in_sel.v ----
// One peripheral input selector: an 8-bit index picks ground, an internal signal or a pin.
// Assumes pin inputs already have analog pins masked off; reserved indices give ground.
`timescale 1ns/1ps
`include "pcnr_defines.vh"

module pcnr_in_sel (
  // Selector index
  input  wire [7:0]  sel,
  // Sources: bit 0 of int_src is ground
  input  wire [12:0] int_src,
  input  wire [15:0] rp_src,
  // Selected level
  output reg         sel_out
);

  // Decode the index into a source
  always @* begin
    sel_out = 1'b0;
    if (sel <= `PCNR_ISEL_INT_LAST) begin
      // Index 0 is ground, 1..12 internal signals
      sel_out = int_src[sel[3:0]];
    end else if (sel >= `PCNR_ISEL_RP_BASE && sel <= `PCNR_ISEL_RP_LAST) begin
      // Remappable pins, offset by the base index
      sel_out = rp_src[sel[3:0]];
    end
  end

endmodule

// ---- verilog/pcnr_top.v ----
// Port change notification and peripheral pin remap, one 16-pin port, APB register slave.
// Assumes pins and peripheral signals are synchronous to pclk; every output is registered.
`timescale 1ns/1ps
`include "pcnr_defines.vh"

module pcnr_top (
  // Clock and reset
  input  wire        pclk,
  input  wire        presetn,
  // APB slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // Device pins
  input  wire [15:0] pin_in,
  output reg  [15:0] pin_out,
  output reg  [15:0] pin_oe,
  // Internal sources for input selection, index 1..12
  input  wire [12:1] internal_sig,
  // Remappable peripheral side
  output reg  [7:0]  periph_in,
  input  wire [7:0]  periph_out,
  input  wire [7:0]  periph_oe,
  // Non-remappable peripheral on its fixed pin
  input  wire [15:0] fixed_en,
  input  wire [15:0] fixed_out,
  input  wire [15:0] fixed_oe,
  // Change notification request
  output reg         notify_irq
);

  // Key sequence states, one-hot
  localparam [2:0] K_IDLE  = 3'b001;
  localparam [2:0] K_FIRST = 3'b010;
  localparam [2:0] K_ARMED = 3'b100;

  // Configuration registers
  reg [15:0] notify_control_reg;          // On bit and style select
  reg [15:0] notify_enable_first_reg;     // First enable per pin
  reg [15:0] notify_enable_second_reg;    // Second enable per pin
  reg [15:0] direction_bits_reg;          // One means input
  reg [15:0] latch_reg;                   // Plain port output data
  reg [15:0] analog_reg;                  // One means analog pin
  reg        map_write_lock_reg;          // Blocks mapping writes
  reg [15:0] input_map_regs [0:3];        // Two 8-bit selectors each
  reg [15:0] output_map_regs [0:7];       // Two 6-bit selectors each

  // Notification state
  reg [15:0] mismatch_status_bits_reg;    // Changed since last value read
  reg [15:0] edge_event_flags_reg;        // Sticky edge events
  reg [15:0] reference_reg;               // Pin state at last value read
  reg [15:0] prev_pin_reg;                // Pin state one cycle ago
  reg [2:0]  key_state_reg;               // Unlock sequence state

  // Next values
  reg [15:0] mismatch_status_bits_next;
  reg [15:0] edge_event_flags_next;
  reg [2:0]  key_state_next;
  reg        map_write_lock_next;
  reg [31:0] rdata_next;
  reg        err_next;
  reg [15:0] pin_out_next;
  reg [15:0] pin_oe_next;

  // Decoded helpers
  wire        notify_on;
  wire        notify_style;
  wire [15:0] din;
  wire [15:0] rise;
  wire [15:0] fall;
  wire [15:0] mismatch_hit;
  wire [15:0] edge_hit;
  wire        xfer_done;
  wire        wr_done;
  wire        rd_done;
  wire [7:0]  periph_sel;
  wire        imap_hit;
  wire        omap_hit;
  wire        any_notify;

  integer     i;
  integer     j;
  integer     k;
  reg  [5:0]  osel;

  assign notify_on    = notify_control_reg[`PCNR_NCTL_ON];
  assign notify_style = notify_control_reg[`PCNR_NCTL_STYLE];

  // Analog pins read as zero on the digital side
  assign din  = pin_in & ~analog_reg;
  assign rise = din & ~prev_pin_reg;
  assign fall = ~din & prev_pin_reg;

  // Mismatch detection against the reference, gated by the first enable
  assign mismatch_hit = {16{notify_on & ~notify_style}} & notify_enable_first_reg
                        & (din ^ reference_reg);

  // Edge detection: both enables choose rising, falling or either
  assign edge_hit = {16{notify_on & notify_style}}
                    & ((notify_enable_first_reg & rise) | (notify_enable_second_reg & fall));

  // Completion edge of an APB access
  assign xfer_done = psel & penable & pready;
  assign wr_done   = xfer_done & pwrite;
  assign rd_done   = xfer_done & ~pwrite;

  // Mapping register windows
  assign imap_hit = (paddr[11:4] == `PCNR_OFS_IMAP >> 4) && (paddr[1:0] == 2'b00);
  assign omap_hit = (paddr[11:5] == `PCNR_OFS_OMAP >> 5) && (paddr[1:0] == 2'b00);

  // Pending request from pins set as inputs only
  assign any_notify = notify_on & (|((notify_style ? edge_event_flags_reg : mismatch_status_bits_reg)
                      & direction_bits_reg));

  // Peripheral input selectors
  genvar g;
  generate
    for (g = 0; g < `PCNR_NPERIN; g = g + 1) begin : gen_in_sel
      pcnr_in_sel u_in_sel (
        .sel     (input_map_regs[g / 2][(g % 2) * 8 +: 8]),
        .int_src ({internal_sig, 1'b0}),
        .rp_src  (din),
        .sel_out (periph_sel[g])
      );
    end
  endgenerate

  // Notification next state
  always @* begin
    // Value read recaptures reference and clears status
    if (rd_done && paddr == `PCNR_OFS_PINVAL) begin
      mismatch_status_bits_next = 16'h0000;
    end else begin
      mismatch_status_bits_next = mismatch_status_bits_reg | mismatch_hit;
    end
    // Software write loads flags from pwdata; a new edge wins over a written zero
    if (wr_done && paddr == `PCNR_OFS_EFLAG) begin
      edge_event_flags_next = pwdata[15:0] | edge_hit;
    end else begin
      edge_event_flags_next = edge_event_flags_reg | edge_hit;
    end
  end

  // Unlock sequence and lock bit
  always @* begin
    key_state_next      = key_state_reg;
    map_write_lock_next = map_write_lock_reg;
    if (wr_done) begin
      case (key_state_reg)
        K_IDLE: begin
          if (paddr == `PCNR_OFS_KEY && pwdata[7:0] == `PCNR_KEY_FIRST) begin
            key_state_next = K_FIRST;
          end
        end
        K_FIRST: begin
          if (paddr == `PCNR_OFS_KEY && pwdata[7:0] == `PCNR_KEY_SECOND) begin
            key_state_next = K_ARMED;
          end else if (paddr == `PCNR_OFS_KEY && pwdata[7:0] == `PCNR_KEY_FIRST) begin
            key_state_next = K_FIRST;
          end else begin
            key_state_next = K_IDLE;
          end
        end
        K_ARMED: begin
          // Single write that updates the lock, any other write abandons
          if (paddr == `PCNR_OFS_MAPCTL) begin
            map_write_lock_next = pwdata[`PCNR_MAPCTL_LOCK];
          end
          key_state_next = K_IDLE;
        end
        default: begin
          key_state_next = K_IDLE;
        end
      endcase
    end
  end

  // Read data and error answer, computed in the first access cycle
  always @* begin
    rdata_next = 32'h0000_0000;
    err_next   = 1'b0;
    if (imap_hit) begin
      rdata_next[15:0] = input_map_regs[paddr[3:2]];
    end else if (omap_hit) begin
      rdata_next[15:0] = output_map_regs[paddr[4:2]] & 16'h3f3f;
    end else begin
      case (paddr)
        `PCNR_OFS_NCTL:       rdata_next[15:0] = notify_control_reg & 16'h8800;
        `PCNR_OFS_EN_FIRST:   rdata_next[15:0] = notify_enable_first_reg;
        `PCNR_OFS_EN_SECOND:  rdata_next[15:0] = notify_enable_second_reg;
        `PCNR_OFS_MSTAT:      rdata_next[15:0] = mismatch_status_bits_reg;
        `PCNR_OFS_EFLAG:      rdata_next[15:0] = edge_event_flags_reg;
        `PCNR_OFS_PINVAL:     rdata_next[15:0] = din;
        `PCNR_OFS_DIR:        rdata_next[15:0] = direction_bits_reg;
        `PCNR_OFS_LATCH:      rdata_next[15:0] = latch_reg;
        `PCNR_OFS_ANALOG:     rdata_next[15:0] = analog_reg;
        `PCNR_OFS_MAPCTL:     rdata_next[`PCNR_MAPCTL_LOCK] = map_write_lock_reg;
        `PCNR_OFS_KEY:        rdata_next = 32'h0000_0000;
        default:              err_next = 1'b1;
      endcase
    end
  end

  // Pin drive: analog first, then remapped peripheral, fixed peripheral, port latch
  always @* begin
    pin_out_next = 16'h0000;
    pin_oe_next  = 16'h0000;
    osel         = `PCNR_OSEL_NULL;
    k            = 0;
    for (i = 0; i < `PCNR_NPIN; i = i + 1) begin
      osel = output_map_regs[i / 2][(i % 2) * 8 +: 6];
      k    = osel - 1;
      if (analog_reg[i]) begin
        // Analog function keeps the pin
        pin_out_next[i] = 1'b0;
        pin_oe_next[i]  = 1'b0;
      end else if (osel != `PCNR_OSEL_NULL && osel <= `PCNR_OSEL_LAST) begin
        // Remapped output overrides all other digital use
        pin_out_next[i] = periph_out[k[2:0]];
        pin_oe_next[i]  = periph_oe[k[2:0]];
      end else if (fixed_en[i]) begin
        // Fixed peripheral on its own pin
        pin_out_next[i] = fixed_out[i];
        pin_oe_next[i]  = fixed_oe[i];
      end else begin
        // Plain port output under direction control
        pin_out_next[i] = latch_reg[i];
        pin_oe_next[i]  = ~direction_bits_reg[i];
      end
    end
  end

  // APB handshake: one wait cycle, then pready with data or error
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & penable & ~pready;
      if (psel && penable && !pready) begin
        prdata  <= pwrite ? 32'h0000_0000 : rdata_next;
        pslverr <= err_next;
      end else begin
        pslverr <= 1'b0;
      end
    end
  end

  // Control and port registers
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      notify_control_reg       <= 16'h0000;
      notify_enable_first_reg  <= 16'h0000;
      notify_enable_second_reg <= 16'h0000;
      direction_bits_reg       <= `PCNR_DIR_RST;
      latch_reg                <= 16'h0000;
      analog_reg               <= `PCNR_ANALOG_RST;
    end else if (wr_done) begin
      case (paddr)
        `PCNR_OFS_NCTL:      notify_control_reg       <= pwdata[15:0] & 16'h8800;
        `PCNR_OFS_EN_FIRST:  notify_enable_first_reg  <= pwdata[15:0];
        `PCNR_OFS_EN_SECOND: notify_enable_second_reg <= pwdata[15:0];
        `PCNR_OFS_DIR:       direction_bits_reg       <= pwdata[15:0];
        `PCNR_OFS_LATCH:     latch_reg                <= pwdata[15:0];
        `PCNR_OFS_ANALOG:    analog_reg               <= pwdata[15:0];
        default:             latch_reg                <= latch_reg;
      endcase
    end
  end

  // Mapping registers, writable only while unlocked
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (j = 0; j < `PCNR_NIMAP; j = j + 1) begin
        input_map_regs[j] <= `PCNR_IMAP_RST;
      end
      for (j = 0; j < `PCNR_NOMAP; j = j + 1) begin
        output_map_regs[j] <= `PCNR_OMAP_RST;
      end
    end else if (wr_done && !map_write_lock_reg) begin
      // Locked writes still complete, contents untouched
      if (imap_hit) begin
        input_map_regs[paddr[3:2]] <= pwdata[15:0];
      end
      if (omap_hit) begin
        output_map_regs[paddr[4:2]] <= pwdata[15:0] & 16'h3f3f;
      end
    end
  end

  // Lock bit and key sequence
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      map_write_lock_reg <= `PCNR_LOCK_RST;
      key_state_reg      <= K_IDLE;
    end else begin
      map_write_lock_reg <= map_write_lock_next;
      key_state_reg      <= key_state_next;
    end
  end

  // Change notification state
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mismatch_status_bits_reg <= 16'h0000;
      edge_event_flags_reg     <= 16'h0000;
      reference_reg            <= 16'h0000;
      prev_pin_reg             <= 16'h0000;
      notify_irq               <= 1'b0;
    end else begin
      mismatch_status_bits_reg <= mismatch_status_bits_next;
      edge_event_flags_reg     <= edge_event_flags_next;
      prev_pin_reg             <= din;
      notify_irq               <= any_notify;
      // Reading the value makes the current pins the new reference
      if (rd_done && paddr == `PCNR_OFS_PINVAL) begin
        reference_reg <= din;
      end
    end
  end

  // Registered pins and peripheral inputs
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_out   <= 16'h0000;
      pin_oe    <= 16'h0000;
      periph_in <= 8'h00;
    end else begin
      pin_out   <= pin_out_next;
      pin_oe    <= pin_oe_next;
      periph_in <= periph_sel;
    end
  end

endmodule
